// ---- rtl/sssp_pkg.sv ----
// Package of the soft start and stop profile sequencer.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package sssp_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACCEL = 8'h04;
  localparam logic [7:0] OFF_DECEL = 8'h08;
  localparam logic [7:0] OFF_START = 8'h0C;
  localparam logic [7:0] OFF_TORQUE = 8'h10;
  localparam logic [7:0] OFF_BRAKE = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_REF = 8'h1C;

  // Control register fields.
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_STOP_LSB = 1;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_PREHEAT_BIT = 4;
  localparam int CTRL_TWO_WIRE_BIT = 5;

  // Setting ranges and reset values in percent or seconds.
  localparam logic [7:0] ACCEL_RST = 8'h0F;
  localparam logic [7:0] DECEL_RST = 8'h0F;
  localparam logic [7:0] TIME_MIN = 8'h01;
  localparam logic [7:0] TIME_MAX = 8'hB4;
  localparam logic [7:0] TQ0_RST = 8'h14;
  localparam logic [7:0] TQ0_MAX = 8'h64;
  localparam logic [7:0] V0_RST = 8'h31;
  localparam logic [7:0] V0_MIN = 8'h19;
  localparam logic [7:0] V0_MAX = 8'h31;
  localparam logic [7:0] FWL_RST = 8'h1E;
  localparam logic [7:0] FWL_MIN = 8'h19;
  localparam logic [7:0] FWL_MAX = 8'h64;
  localparam logic [7:0] GAIN_RST = 8'h28;
  localparam logic [7:0] GAIN_MIN = 8'h0A;
  localparam logic [7:0] GAIN_MAX = 8'h32;
  localparam logic [7:0] TLIM_OFF = 8'h00;
  localparam logic [7:0] TLIM_MIN = 8'h0A;
  localparam logic [7:0] TLIM_MAX = 8'hC8;
  localparam logic [7:0] LSC_RST = 8'h19;
  localparam logic [7:0] LSC_MAX = 8'h5A;
  localparam logic [7:0] BRK_RST = 8'h32;
  localparam logic [7:0] BRK_MAX = 8'h64;
  localparam logic [7:0] DCR_RST = 8'h14;
  localparam logic [7:0] DCR_MIN = 8'h14;
  localparam logic [7:0] DCR_MAX = 8'h64;
  localparam logic [7:0] PCT_FULL = 8'h64;

  // Longest dynamic braking time in seconds, at zero braking level.
  localparam logic [7:0] BRAKE_T1_MAX_S = 8'h14;

  // Clock and ramp update timing.
  localparam int CLK_HZ = 40000000;
  localparam int UPDATE_HZ = 1000;
  localparam int TICK_CYCLES = CLK_HZ / UPDATE_HZ;

  typedef enum logic [1:0] {
    SSSP_MODE_TORQUE = 2'b00,
    SSSP_MODE_VOLTAGE = 2'b01
  } sssp_mode_t;

  typedef enum logic [1:0] {
    SSSP_STOP_FREEWHEEL = 2'b00,
    SSSP_STOP_DECEL = 2'b01,
    SSSP_STOP_BRAKE = 2'b10
  } sssp_stop_t;

  typedef enum logic [2:0] {
    SSSP_IDLE = 3'b000,
    SSSP_ACCEL = 3'b001,
    SSSP_BYPASS = 3'b010,
    SSSP_DECEL = 3'b011,
    SSSP_BRAKE = 3'b100,
    SSSP_DCINJ = 3'b101,
    SSSP_PREHEAT = 3'b110
  } sssp_state_t;

endpackage

// ---- rtl/sssp_top.sv ----
// Start, stop and braking profile sequencer with an APB register file.
// Assumes a synchronous motor_steady flag and a torque estimate from the power stage.
// Function
// - Torque mode ramps reference from start torque to nominal over acceleration time.
// - Enter bypassed state once motor runs steady, even before ramp ends.
// - Voltage mode ramps from initial voltage to full mains unless current limited.
// - Initial torque 0 to 100 percent, default 20, rejected above torque ceiling.
// - Torque stop ramps from estimate at stop down to zero over decel time.
// - Voltage stop ramps from 100 percent to threshold, then drops to zero.
// - Freewheel threshold 25 to 100, default 30, only voltage mode decel stop.
// - Deceleration time usable only when a controlled deceleration is selected.
// - Decel gain default 40 applies only in torque mode with decel stop.
// - Torque ceiling off or percent; sets ramp end and clamps reference except in braking and DC injection.
// - Torque ceiling usable only in torque control mode.
// - Stator loss factor, default 25, used only in torque mode estimate.
// - Brake stop is dynamic phase T1 then DC injection of T1 times ratio.
// - Brake strength 0 to 100, default 50; higher means shorter T1.
// - DC injection ratio 20 to 100 percent, default 20.
// - Brake settings usable only with braking stop; braking follows strength.
// - DC injection drives two motor phases.
// - Thermal monitoring is suspended while preheating.
// - Preheating refused with hardwired two-wire control.
// - Mode selects torque or voltage control, torque by default.
// - Initial voltage 25 to 49 percent, default 49.
`timescale 1ns/1ps
module sssp_top #(
  parameter int TICK_CYCLES = sssp_pkg::TICK_CYCLES,
  parameter int UPDATE_HZ = sssp_pkg::UPDATE_HZ
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power stage side
  input wire logic motor_steady,
  input wire logic current_limited,
  input wire logic error_stop,
  input wire logic [7:0] torque_raw,
  output logic [7:0] torque_ref,
  output logic [7:0] voltage_ref,
  output logic dc_inject,
  output logic [1:0] phase_enable,
  output logic bypassed_state,
  output logic thermal_monitor_en,
  output logic preheat_active
);

  typedef struct packed {
    logic mode;
    logic [1:0] stop_type;
    logic run;
    logic preheat_req;
    logic two_wire;
    logic [7:0] accel_ramp_time;
    logic [7:0] decel_time;
    logic [7:0] initial_start_torque;
    logic [7:0] initial_start_voltage;
    logic [7:0] freewheel_voltage_threshold;
    logic [7:0] torque_decel_gain;
    logic [7:0] torque_ceiling;
    logic [7:0] stator_loss_comp;
    logic [7:0] dynamic_brake_strength;
    logic [7:0] dc_injection_ratio;
    sssp_pkg::sssp_state_t state;
    logic [31:0] tick_cnt;
    logic [31:0] step_cnt;
    logic [31:0] step_total;
    logic [7:0] ramp_from;
    logic [7:0] ramp_to;
    logic [7:0] ref_q;
    logic [31:0] rdata;
  } sssp_regs_t;

  sssp_regs_t r_q;
  sssp_regs_t r_d;

  logic wr_en;
  logic rd_en;
  logic tick;
  logic [7:0] torque_est;
  logic [7:0] ramp_val;
  logic [7:0] accel_end;
  logic [7:0] t1_s;
  logic [15:0] t2_s;

  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Steps in a ramp lasting the given seconds.
  function automatic logic [31:0] steps_of(input logic [15:0] secs);
    steps_of = 32'(secs) * 32'(UPDATE_HZ);
  endfunction

  function automatic logic [7:0] lerp(input logic [7:0] a, input logic [7:0] b,
                                      input logic [31:0] n, input logic [31:0] tot);
    logic [47:0] span;
    span = 48'((b > a) ? (b - a) : (a - b)) * 48'(n);
    if (tot == 32'h0)
      lerp = b;
    else if (b > a)
      lerp = 8'(48'(a) + span / 48'(tot));
    else
      lerp = 8'(48'(a) - span / 48'(tot));
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign tick = (r_q.tick_cnt == 32'(TICK_CYCLES - 1));

  assign torque_est = (r_q.mode == 1'b0) ?
    8'((16'(torque_raw) * (16'd100 + 16'(r_q.stator_loss_comp))) / 16'd125) : torque_raw;

  assign accel_end = (r_q.torque_ceiling == sssp_pkg::TLIM_OFF) ? sssp_pkg::PCT_FULL
                     : r_q.torque_ceiling;

  assign t1_s = 8'((16'(sssp_pkg::BRAKE_T1_MAX_S) *
                   (16'd200 - 16'(r_q.dynamic_brake_strength))) / 16'd200);

  assign t2_s = (16'(t1_s) * 16'(r_q.dc_injection_ratio)) / 16'(sssp_pkg::PCT_FULL);

  assign ramp_val = lerp(r_q.ramp_from, r_q.ramp_to, r_q.step_cnt, r_q.step_total);

  always_comb
  begin
    r_d = r_q;
    if (tick)
      r_d.tick_cnt = 32'h0;
    else
      r_d.tick_cnt = r_q.tick_cnt + 32'h1;
    r_d.rdata = 32'h0;
    if (wr_en)
    begin
      case (paddr)
        sssp_pkg::OFF_CTRL:
        begin
          r_d.mode = pwdata[sssp_pkg::CTRL_MODE_BIT];
          if (pwdata[sssp_pkg::CTRL_STOP_LSB +: 2] != 2'b11)
            r_d.stop_type = pwdata[sssp_pkg::CTRL_STOP_LSB +: 2];
          r_d.run = pwdata[sssp_pkg::CTRL_RUN_BIT];
          r_d.preheat_req = pwdata[sssp_pkg::CTRL_PREHEAT_BIT];
          r_d.two_wire = pwdata[sssp_pkg::CTRL_TWO_WIRE_BIT];
        end
        sssp_pkg::OFF_ACCEL:
          if (in_range(pwdata[7:0], sssp_pkg::TIME_MIN, sssp_pkg::TIME_MAX))
            r_d.accel_ramp_time = pwdata[7:0];
        sssp_pkg::OFF_DECEL:
        begin
          if (r_q.stop_type == sssp_pkg::SSSP_STOP_DECEL &&
              in_range(pwdata[7:0], sssp_pkg::TIME_MIN, sssp_pkg::TIME_MAX))
            r_d.decel_time = pwdata[7:0];
          if (r_q.mode == 1'b1 && r_q.stop_type == sssp_pkg::SSSP_STOP_DECEL &&
              in_range(pwdata[15:8], sssp_pkg::FWL_MIN, sssp_pkg::FWL_MAX))
            r_d.freewheel_voltage_threshold = pwdata[15:8];
          if (r_q.mode == 1'b0 && r_q.stop_type == sssp_pkg::SSSP_STOP_DECEL &&
              in_range(pwdata[23:16], sssp_pkg::GAIN_MIN, sssp_pkg::GAIN_MAX))
            r_d.torque_decel_gain = pwdata[23:16];
        end
        sssp_pkg::OFF_START:
        begin
          if (pwdata[7:0] <= sssp_pkg::TQ0_MAX &&
              (r_q.torque_ceiling == sssp_pkg::TLIM_OFF || pwdata[7:0] <= r_q.torque_ceiling))
            r_d.initial_start_torque = pwdata[7:0];
          if (r_q.mode == 1'b1 && in_range(pwdata[15:8], sssp_pkg::V0_MIN, sssp_pkg::V0_MAX))
            r_d.initial_start_voltage = pwdata[15:8];
        end
        sssp_pkg::OFF_TORQUE:
        begin
          if (r_q.mode == 1'b0 && (pwdata[7:0] == sssp_pkg::TLIM_OFF ||
              in_range(pwdata[7:0], sssp_pkg::TLIM_MIN, sssp_pkg::TLIM_MAX)))
            r_d.torque_ceiling = pwdata[7:0];
          if (r_q.mode == 1'b0 && pwdata[15:8] <= sssp_pkg::LSC_MAX)
            r_d.stator_loss_comp = pwdata[15:8];
        end
        sssp_pkg::OFF_BRAKE:
        begin
          if (r_q.stop_type == sssp_pkg::SSSP_STOP_BRAKE)
          begin
            if (pwdata[7:0] <= sssp_pkg::BRK_MAX)
              r_d.dynamic_brake_strength = pwdata[7:0];
            if (in_range(pwdata[15:8], sssp_pkg::DCR_MIN, sssp_pkg::DCR_MAX))
              r_d.dc_injection_ratio = pwdata[15:8];
          end
        end
        default:
        begin
        end
      endcase
    end
    if (rd_en)
    begin
      case (paddr)
        sssp_pkg::OFF_CTRL:
          r_d.rdata = {26'h0, r_q.two_wire, r_q.preheat_req, r_q.run, r_q.stop_type, r_q.mode};
        sssp_pkg::OFF_ACCEL:
          r_d.rdata = {24'h0, r_q.accel_ramp_time};
        sssp_pkg::OFF_DECEL:
          r_d.rdata = {8'h0, r_q.torque_decel_gain, r_q.freewheel_voltage_threshold,
                       r_q.decel_time};
        sssp_pkg::OFF_START:
          r_d.rdata = {16'h0, r_q.initial_start_voltage, r_q.initial_start_torque};
        sssp_pkg::OFF_TORQUE:
          r_d.rdata = {16'h0, r_q.stator_loss_comp, r_q.torque_ceiling};
        sssp_pkg::OFF_BRAKE:
          r_d.rdata = {16'h0, r_q.dc_injection_ratio, r_q.dynamic_brake_strength};
        sssp_pkg::OFF_STATUS:
          r_d.rdata = {21'h0, r_q.state, torque_est};
        sssp_pkg::OFF_REF:
          r_d.rdata = {24'h0, r_q.ref_q};
        default:
          r_d.rdata = 32'h0;
      endcase
    end

    if (tick && r_q.step_cnt < r_q.step_total)
      r_d.step_cnt = r_q.step_cnt + 32'h1;

    case (r_q.state)
      sssp_pkg::SSSP_IDLE:
      begin
        r_d.ref_q = 8'h0;
        if (r_q.run)
        begin
          r_d.state = sssp_pkg::SSSP_ACCEL;
          r_d.step_cnt = 32'h0;
          r_d.step_total = steps_of(16'(r_q.accel_ramp_time));
          r_d.ramp_from = r_q.mode ? r_q.initial_start_voltage : r_q.initial_start_torque;
          r_d.ramp_to = r_q.mode ? sssp_pkg::PCT_FULL : accel_end;
        end
        else if (r_q.preheat_req && !r_q.two_wire)
          r_d.state = sssp_pkg::SSSP_PREHEAT;
      end
      sssp_pkg::SSSP_PREHEAT:
        if (!r_q.preheat_req || r_q.run || r_q.two_wire)
          r_d.state = sssp_pkg::SSSP_IDLE;
      sssp_pkg::SSSP_ACCEL:
      begin
        if (r_q.mode && current_limited && tick)
          r_d.step_cnt = r_q.step_cnt;
        r_d.ref_q = (r_q.mode && current_limited && r_q.ref_q != 8'h0) ? r_q.ref_q : ramp_val;
        if (motor_steady || r_q.step_cnt == r_q.step_total)
          r_d.state = sssp_pkg::SSSP_BYPASS;
        if (!r_q.run || error_stop)
          r_d.state = sssp_pkg::SSSP_BYPASS;
      end
      sssp_pkg::SSSP_BYPASS:
      begin
        r_d.ref_q = r_q.mode ? sssp_pkg::PCT_FULL : accel_end;
        if (!r_q.run || error_stop)
        begin
          r_d.step_cnt = 32'h0;
          case (r_q.stop_type)
            sssp_pkg::SSSP_STOP_DECEL:
            begin
              r_d.state = sssp_pkg::SSSP_DECEL;
              r_d.step_total = steps_of(16'(r_q.decel_time));
              r_d.ramp_from = r_q.mode ? sssp_pkg::PCT_FULL : torque_est;
              r_d.ramp_to = 8'h0;
            end
            sssp_pkg::SSSP_STOP_BRAKE:
            begin
              r_d.state = sssp_pkg::SSSP_BRAKE;
              r_d.step_total = steps_of(16'(t1_s));
            end
            default:
              r_d.state = sssp_pkg::SSSP_IDLE;
          endcase
        end
      end
      sssp_pkg::SSSP_DECEL:
      begin
        r_d.ref_q = r_q.mode ? ramp_val :
          8'((16'(ramp_val) * (16'd60 + 16'(r_q.torque_decel_gain))) / 16'd100);
        if ((r_q.mode && ramp_val < r_q.freewheel_voltage_threshold) ||
            r_q.step_cnt == r_q.step_total)
        begin
          r_d.ref_q = 8'h0;
          r_d.state = sssp_pkg::SSSP_IDLE;
        end
      end
      sssp_pkg::SSSP_BRAKE:
      begin
        r_d.ref_q = r_q.dynamic_brake_strength;
        if (r_q.step_cnt == r_q.step_total)
        begin
          r_d.state = sssp_pkg::SSSP_DCINJ;
          r_d.step_cnt = 32'h0;
          r_d.step_total = steps_of(t2_s);
        end
      end
      sssp_pkg::SSSP_DCINJ:
      begin
        r_d.ref_q = r_q.dynamic_brake_strength;
        if (r_q.step_cnt == r_q.step_total)
        begin
          r_d.ref_q = 8'h0;
          r_d.state = sssp_pkg::SSSP_IDLE;
        end
      end
      default:
        r_d.state = sssp_pkg::SSSP_IDLE;
    endcase

    if (!r_q.mode && r_q.torque_ceiling != sssp_pkg::TLIM_OFF &&
        r_d.ref_q > r_q.torque_ceiling && r_d.state != sssp_pkg::SSSP_BRAKE &&
        r_d.state != sssp_pkg::SSSP_DCINJ)
      r_d.ref_q = r_q.torque_ceiling;
  end

  // A read returns data latched in setup, so pready can stay high.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q <= '0;
      r_q.accel_ramp_time <= sssp_pkg::ACCEL_RST;
      r_q.decel_time <= sssp_pkg::DECEL_RST;
      r_q.initial_start_torque <= sssp_pkg::TQ0_RST;
      r_q.initial_start_voltage <= sssp_pkg::V0_RST;
      r_q.freewheel_voltage_threshold <= sssp_pkg::FWL_RST;
      r_q.torque_decel_gain <= sssp_pkg::GAIN_RST;
      r_q.torque_ceiling <= sssp_pkg::TLIM_OFF;
      r_q.stator_loss_comp <= sssp_pkg::LSC_RST;
      r_q.dynamic_brake_strength <= sssp_pkg::BRK_RST;
      r_q.dc_injection_ratio <= sssp_pkg::DCR_RST;
      r_q.state <= sssp_pkg::SSSP_IDLE;
    end
    else if (clk_en)
    begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.rdata;
  assign torque_ref = r_q.mode ? 8'h0 : r_q.ref_q;
  assign voltage_ref = r_q.mode ? r_q.ref_q : 8'h0;
  assign bypassed_state = (r_q.state == sssp_pkg::SSSP_BYPASS);
  assign dc_inject = (r_q.state == sssp_pkg::SSSP_DCINJ);
  assign phase_enable = (r_q.state == sssp_pkg::SSSP_DCINJ) ? 2'b11 : 2'b00;
  assign preheat_active = (r_q.state == sssp_pkg::SSSP_PREHEAT);
  assign thermal_monitor_en = (r_q.state != sssp_pkg::SSSP_PREHEAT);

endmodule

// ---- verif/sssp_properties.sv ----
// Checker of the profile sequencer outputs, bound to the top module.
// Assumes the top module ports of the design and a single pclk domain.
`timescale 1ns/1ps
module sssp_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Bus answer
  input wire logic pready,
  input wire logic pslverr,
  // Power stage side
  input wire logic current_limited,
  input wire logic [7:0] torque_ref,
  input wire logic [7:0] voltage_ref,
  input wire logic dc_inject,
  input wire logic [1:0] phase_enable,
  input wire logic bypassed_state,
  input wire logic thermal_monitor_en,
  input wire logic preheat_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  bus_ready_a: assert property (pready && !pslverr)
    else $error("bus answer wrong");
  dc_phases_a: assert property (dc_inject |-> phase_enable == 2'b11)
    else $error("phases off during injection");
  heat_thermal_a: assert property (thermal_monitor_en == !preheat_active)
    else $error("thermal monitor wrong");
  volt_max_a: assert property (voltage_ref <= 8'h64)
    else $error("voltage above full");
  mode_excl_a: assert property (!(torque_ref != 8'h00 && voltage_ref != 8'h00))
    else $error("both references active");
  // A stalled update must freeze every ramp, or timing drifts.
  freeze_ref_a: assert property (!clk_en |=> $stable(torque_ref) && $stable(voltage_ref))
    else $error("reference moved while frozen");
  limit_hold_a: assert property (current_limited && voltage_ref != 8'h00 && !dc_inject
    |=> voltage_ref <= $past(voltage_ref))
    else $error("voltage rose while limited");
  inject_excl_a: assert property (dc_inject |-> !bypassed_state && !preheat_active)
    else $error("injection in wrong state");
  inject_start_a: assert property ($rose(dc_inject) |-> !$past(bypassed_state))
    else $error("injection without braking phase");
  cover property ($rose(dc_inject));
  cover property ($rose(bypassed_state));
  cover property ($rose(preheat_active));
  cover property (current_limited && voltage_ref != 8'h00);
endmodule
bind sssp_top sssp_properties i_sssp_properties (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .pready(pready), .pslverr(pslverr), .current_limited(current_limited),
  .torque_ref(torque_ref), .voltage_ref(voltage_ref), .dc_inject(dc_inject),
  .phase_enable(phase_enable), .bypassed_state(bypassed_state),
  .thermal_monitor_en(thermal_monitor_en), .preheat_active(preheat_active));

// ---- verif/sssp_power_stage.sv ----
// Behavioural motor and power stage facing the sequencer.
// Assumes the motor runs steady a set number of cycles after being energised.
`timescale 1ns/1ps
module sssp_power_stage (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From the sequencer
  input wire logic [7:0] torque_ref,
  input wire logic [7:0] voltage_ref,
  input wire logic bypassed_state,
  // Load setup, zero steady_after means never steady
  input wire logic [7:0] steady_after,
  input wire logic [7:0] load_pct,
  // To the sequencer
  output logic motor_steady,
  output logic [7:0] torque_raw
);
  logic [7:0] cnt_q;
  logic on;
  assign on = bypassed_state || torque_ref != 8'h00 || voltage_ref != 8'h00;
  // A motor with no drive shows no torque, not the last one seen.
  assign torque_raw = on ? load_pct : 8'h00;
  assign motor_steady = on && steady_after != 8'h00 && cnt_q >= steady_after;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 8'h00;
    else if (!on)
      cnt_q <= 8'h00;
    else if (cnt_q != 8'hFF)
      cnt_q <= cnt_q + 8'h01;
  end
endmodule

// ---- verif/sssp_top_bench.sv ----
// Self-checking bench of the profile sequencer over APB.
// Assumes a fast update tick so that second-scale ramps take few cycles.
`timescale 1ns/1ps
module sssp_top_bench;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic current_limited, error_stop, motor_steady, dc_inject, bypassed_state;
  logic thermal_monitor_en, preheat_active;
  logic [7:0] paddr, torque_raw, torque_ref, voltage_ref, steady_after, load_pct, mx, lv;
  logic [1:0] phase_enable;
  logic [31:0] pwdata, prdata, rd;
  int num_errors, n_compared, n, t1;
  // Two cycles a tick and four ticks a second keep ramps short.
  sssp_top #(.TICK_CYCLES(2), .UPDATE_HZ(4)) i_sssp_top (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_steady(motor_steady), .current_limited(current_limited),
    .error_stop(error_stop), .torque_raw(torque_raw), .torque_ref(torque_ref),
    .voltage_ref(voltage_ref), .dc_inject(dc_inject), .phase_enable(phase_enable),
    .bypassed_state(bypassed_state), .thermal_monitor_en(thermal_monitor_en),
    .preheat_active(preheat_active));
  sssp_power_stage i_sssp_power_stage (.pclk(pclk), .presetn(presetn),
    .torque_ref(torque_ref), .voltage_ref(voltage_ref), .bypassed_state(bypassed_state),
    .steady_after(steady_after), .load_pct(load_pct), .motor_steady(motor_steady),
    .torque_raw(torque_raw));
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask
  task wait_byp;
    n = 0;
    mx = 8'h00;
    while (bypassed_state !== 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
      if (torque_ref > mx)
        mx = torque_ref;
      if (voltage_ref > mx)
        mx = voltage_ref;
    end
  endtask
  task brake(input logic [7:0] s, input logic [7:0] r, input int e1, input int e2);
    wr(sssp_pkg::OFF_BRAKE, {16'h0, r, s});
    wr(sssp_pkg::OFF_CTRL, 32'hC);
    wait_byp;
    wr(sssp_pkg::OFF_CTRL, 32'h4);
    t1 = 0;
    while (dc_inject !== 1'b1 && t1 < 400)
    begin
      @(posedge pclk);
      t1++;
    end
    chk("inject phases", 32'h3, {30'h0, phase_enable});
    n = 0;
    while (dc_inject === 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk("brake time", 32'h1, {31'h0, t1 > e1 - 8 && t1 < e1 + 8});
    chk("inject time", 32'h1, {31'h0, n > e2 - 6 && n < e2 + 6});
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    #(25 * 20000);
    num_errors++;
    close_out;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, current_limited, error_stop} = 6'h0;
    clk_en = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    steady_after = 8'h00;
    load_pct = 8'h28;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(sssp_pkg::OFF_CTRL, 32'h0);
    rc(sssp_pkg::OFF_ACCEL, 32'h0F);
    rc(sssp_pkg::OFF_DECEL, 32'h00281E0F);
    rc(sssp_pkg::OFF_START, 32'h3114);
    rc(sssp_pkg::OFF_TORQUE, 32'h1900);
    rc(sssp_pkg::OFF_BRAKE, 32'h1432);
    rc(8'h20, 32'h0);
    wr(sssp_pkg::OFF_DECEL, 32'h00281E05);
    rc(sssp_pkg::OFF_DECEL, 32'h00281E0F);
    wr(sssp_pkg::OFF_BRAKE, 32'h6464);
    rc(sssp_pkg::OFF_BRAKE, 32'h1432);
    wr(sssp_pkg::OFF_TORQUE, 32'h1932);
    rc(sssp_pkg::OFF_TORQUE, 32'h1932);
    wr(sssp_pkg::OFF_START, 32'h3140);
    rc(sssp_pkg::OFF_START, 32'h3114);
    wr(sssp_pkg::OFF_START, 32'h3128);
    wr(sssp_pkg::OFF_CTRL, 32'h3);
    wr(sssp_pkg::OFF_TORQUE, 32'h1964);
    rc(sssp_pkg::OFF_TORQUE, 32'h1932);
    wr(sssp_pkg::OFF_START, 32'h1828);
    rc(sssp_pkg::OFF_START, 32'h3128);
    wr(sssp_pkg::OFF_DECEL, 32'h00284005);
    wr(sssp_pkg::OFF_DECEL, 32'h00281805);
    rc(sssp_pkg::OFF_DECEL, 32'h00284005);
    $display("test settings done");
    wr(sssp_pkg::OFF_ACCEL, 32'h1);
    wr(sssp_pkg::OFF_CTRL, 32'hB);
    n = 0;
    while (voltage_ref === 8'h00 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk("start voltage", 32'h31, {24'h0, voltage_ref});
    current_limited <= 1'b1;
    repeat (4) @(posedge pclk);
    current_limited <= 1'b0;
    clk_en <= 1'b0;
    repeat (4) @(posedge pclk);
    clk_en <= 1'b1;
    wait_byp;
    chk("full voltage", 32'h64, {24'h0, mx});
    error_stop <= 1'b1;
    n = 0;
    lv = 8'h00;
    while (voltage_ref !== 8'h00 && n < 400)
    begin
      lv = voltage_ref;
      @(posedge pclk);
      n++;
    end
    chk("coast level", 32'h1, {31'h0, lv >= 8'h40 && n < 400});
    wr(sssp_pkg::OFF_CTRL, 32'h3);
    error_stop <= 1'b0;
    repeat (40) @(posedge pclk);
    rc(sssp_pkg::OFF_STATUS, {21'h0, sssp_pkg::SSSP_IDLE, 8'h00});
    $display("test voltage done");
    wr(sssp_pkg::OFF_CTRL, 32'h2);
    wr(sssp_pkg::OFF_DECEL, 32'h00284001);
    wr(sssp_pkg::OFF_CTRL, 32'hA);
    wait_byp;
    chk("accel time", 32'h1, {31'h0, n >= 4 && n <= 20});
    chk("ramp end", 32'h32, {24'h0, mx});
    rc(sssp_pkg::OFF_STATUS, {21'h0, sssp_pkg::SSSP_BYPASS, 8'h28});
    wr(sssp_pkg::OFF_TORQUE, 32'h4B32);
    rc(sssp_pkg::OFF_STATUS, {21'h0, sssp_pkg::SSSP_BYPASS, 8'h38});
    wr(sssp_pkg::OFF_CTRL, 32'h2);
    n = 0;
    while (torque_ref !== 8'h00 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk("decel time", 32'h1, {31'h0, n >= 2 && n <= 14});
    wr(sssp_pkg::OFF_ACCEL, 32'hA);
    steady_after <= 8'h03;
    wr(sssp_pkg::OFF_CTRL, 32'hA);
    wait_byp;
    chk("early bypass", 32'h1, {31'h0, n <= 20});
    $display("test torque done");
    wr(sssp_pkg::OFF_CTRL, 32'h4);
    for (int k = 0; k < 2; k++)
      brake(k ? 8'h00 : 8'h64, k ? 8'h32 : 8'h14, k ? 160 : 80, k ? 80 : 16);
    $display("test brake done");
    wr(sssp_pkg::OFF_CTRL, 32'h10);
    n = 0;
    while (preheat_active !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    chk("preheat on", 32'h1, {31'h0, preheat_active});
    chk("thermal monitor", 32'h0, {31'h0, thermal_monitor_en});
    wr(sssp_pkg::OFF_CTRL, 32'h30);
    repeat (2) @(posedge pclk);
    chk("preheat off", 32'h0, {31'h0, preheat_active});
    wr(sssp_pkg::OFF_CTRL, 32'h0);
    wr(sssp_pkg::OFF_CTRL, 32'h30);
    repeat (4) @(posedge pclk);
    chk("preheat refused", 32'h0, {31'h0, preheat_active});
    $display("test preheat done");
    close_out;
  end
endmodule
